//--- core/dpch_consts.svh
// Constants for the drive procedure command handshake block
`ifndef DPCH_CONSTS_SVH
`define DPCH_CONSTS_SVH

`define DPCH_CTL_SET_BIT 0
`define DPCH_CTL_START_BIT 1
`define DPCH_STS_SET_BIT 0
`define DPCH_STS_RUN_BIT 1
`define DPCH_STS_BUSY_BIT 2
`define DPCH_STS_ERR_BIT 3
`define DPCH_DSW_CHANGE_BIT 5
`define DPCH_STS_RESET 8'h00
`define DPCH_DSW_RESET 16'h0000
`define DPCH_ATTR_TYPE_LSB 20
`define DPCH_ATTR_TYPE_MSB 22
`define DPCH_ATTR_PROC_BIT 19
`define DPCH_ATTR_LEN_LSB 16
`define DPCH_ATTR_LEN_MSB 18
`define DPCH_ATTR_LEN_MASK 32'h00070000
`define DPCH_ATTR_DEC_LSB 24
`define DPCH_ATTR_DEC_MSB 27
`define DPCH_ATTR_CONV_MSB 15

`endif

//--- core/dpch_pkg.sv
// Types for the drive procedure command handshake block
package dpch_pkg;

  typedef enum logic [2:0] {
    DPCH_TYPE_BIN = 3'h0,
    DPCH_TYPE_UINT = 3'h1,
    DPCH_TYPE_SINT = 3'h2,
    DPCH_TYPE_HEX = 3'h3,
    DPCH_TYPE_STR = 3'h4,
    DPCH_TYPE_IDENT = 3'h5,
    DPCH_TYPE_FLOAT = 3'h6,
    DPCH_TYPE_RSVD = 3'h7
  } dpch_type_t;

  typedef enum logic [1:0] {
    DPCH_IDLE = 2'b00,
    DPCH_SET = 2'b01,
    DPCH_BUSY = 2'b10,
    DPCH_DONE = 2'b11
  } dpch_state_t;

endpackage

//--- core/dpch_attr_if.sv
// Decoded attribute word fields passed from decoder to top
`timescale 1ns/10ps
interface dpch_attr_if;
  logic [2:0] data_type;
  logic type_valid;
  logic is_signed;
  logic is_float;
  logic fixed_len;
  logic len_valid;
  logic [3:0] elem_bytes;
  logic is_proc;
  logic [3:0] decimals;
  logic [15:0] conv_factor;
  modport dec (output data_type, type_valid, is_signed, is_float,
    fixed_len, len_valid, elem_bytes, is_proc, decimals, conv_factor);
  modport use_side (input data_type, type_valid, is_signed, is_float,
    fixed_len, len_valid, elem_bytes, is_proc, decimals, conv_factor);
endinterface

//--- core/dpch_attr_decode.sv
// Decoder of the 32-bit parameter attribute word
`timescale 1ns/10ps
`include "dpch_consts.svh"
module dpch_attr_decode import dpch_pkg::*; (
  // Attribute word
  input wire logic [31:0] attr,
  // Decoded fields
  dpch_attr_if.dec dec
);
  wire logic [2:0] type_code;
  wire logic [2:0] len_code;
  assign type_code = attr[`DPCH_ATTR_TYPE_MSB:`DPCH_ATTR_TYPE_LSB];
  assign len_code = attr[`DPCH_ATTR_LEN_MSB:`DPCH_ATTR_LEN_LSB];

  assign dec.data_type = type_code;
  assign dec.type_valid = (type_code != DPCH_TYPE_RSVD);
  assign dec.is_signed = (type_code == DPCH_TYPE_SINT) ||
    (type_code == DPCH_TYPE_FLOAT);
  assign dec.is_float = (type_code == DPCH_TYPE_FLOAT);
  // Code 000 reserved, 001..011 fixed 2/4/8 bytes
  assign dec.len_valid = (len_code != 3'h0);
  assign dec.fixed_len = ~len_code[2];
  // Fixed: 2<<(code-1); variable: element 1<<(code-4)
  assign dec.elem_bytes = len_code[2] ?
    (4'h1 << len_code[1:0]) :
    ((len_code == 3'h0) ? 4'h0 : (4'h1 << len_code[1:0]));
  assign dec.is_proc = attr[`DPCH_ATTR_PROC_BIT];
  assign dec.decimals = attr[`DPCH_ATTR_DEC_MSB:`DPCH_ATTR_DEC_LSB];
  assign dec.conv_factor = attr[`DPCH_ATTR_CONV_MSB:0];
endmodule // dpch_attr_decode

//--- core/dpch_sync.sv
// Two-flop synchroniser for a level from outside the clock domain
`timescale 1ns/10ps
module dpch_sync (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // Level
  input wire logic d,
  output logic q
);
  logic meta_ff;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_ff <= 1'b0;
      q <= 1'b0;
    end else if (clk_en) begin
      meta_ff <= d;
      q <= meta_ff;
    end
  end
endmodule // dpch_sync

//--- core/dpch_core.sv
// Drive-side procedure command handshake with attribute decoding
`timescale 1ns/10ps
`include "dpch_consts.svh"
// Contract
// - Attribute type codes 000..111 decoded, 111 reserved
// - Length field mask 00070000, fixed 2/4/8, 000
// - Length codes 100..111 variable, 1/2/4/8-byte elements
// - Control bit 0 sets or cancels procedure
// - Control bit 1 starts or interrupts procedure
// - Status bit 0 reads one while set
// - Status bit 1 reads one while running
// - Status bit 2 busy until finished correctly; code also clears it on failure, with bit 3 set
// - Status bit 3 flags failed execution
// - Control bits echoed, device drives bits 2,3; code echoes bit 1 only when bit 0 is written as one, else it reads zero
// - Change flag on busy fall or error rise
// - Status word sent in every cyclic reply
// - Change flag cleared when idle or control changes
// - Write of zero clears status and change flag
module dpch_core import dpch_pkg::*; (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // Procedure command write from service channel
  input wire logic cmd_wr,
  input wire logic [7:0] cmd_wdata,
  // Procedure execution report from drive function
  input wire logic proc_done,
  input wire logic proc_fail,
  // Cyclic reply strobe and drive status word from other logic
  input wire logic cycle_tick,
  input wire logic [15:0] dsw_in,
  // Attribute word of the addressed parameter
  input wire logic [31:0] attr_word,
  // Procedure command status read value
  output logic [7:0] proc_status,
  // Control outputs to drive function
  output logic proc_armed,
  output logic proc_run,
  // Drive status word for the cyclic reply
  output logic [15:0] reply_dsw,
  output logic reply_valid,
  // Decoded attribute
  output logic [2:0] attr_type,
  output logic attr_type_ok,
  output logic attr_fixed,
  output logic attr_len_ok,
  output logic [3:0] attr_elem_bytes
);
  dpch_attr_if attr_bus ();

  logic done_s;
  logic fail_s;
  dpch_state_t state_ff, nxt_state;
  logic set_ff, run_ff, busy_ff, err_ff, chg_ff;
  logic nxt_set, nxt_run, nxt_busy, nxt_err, nxt_chg;

  // Drive function reports come from outside this clock
  dpch_sync u_sync_done (
    .clk(clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .d(proc_done),
    .q(done_s)
  );

  dpch_sync u_sync_fail (
    .clk(clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .d(proc_fail),
    .q(fail_s)
  );

  dpch_attr_decode u_attr (
    .attr(attr_word),
    .dec(attr_bus)
  );

  // Write decode; only bits 0 and 1 matter
  wire logic wr_set;
  wire logic wr_run;
  wire logic ctl_change;
  wire logic wr_zero;
  wire logic busy_fall;
  wire logic err_rise;
  assign wr_set = cmd_wdata[`DPCH_CTL_SET_BIT];
  assign wr_run = cmd_wdata[`DPCH_CTL_START_BIT];
  assign ctl_change = cmd_wr && ((wr_set != set_ff) || (wr_run != run_ff));
  assign wr_zero = cmd_wr && !wr_set && !wr_run;
  // A drop forced by cancel is not a completion event
  assign busy_fall = busy_ff && !nxt_busy && nxt_set;
  assign err_rise = !err_ff && nxt_err;

  always_comb begin
    nxt_state = state_ff;
    nxt_set = set_ff;
    nxt_run = run_ff;
    nxt_busy = busy_ff;
    nxt_err = err_ff;
    if (cmd_wr) begin
      nxt_set = wr_set;
      nxt_run = wr_set && wr_run;
    end
    case (state_ff)
      DPCH_IDLE: begin
        if (nxt_set && nxt_run) begin
          nxt_state = DPCH_BUSY; // Set and start in one write
          nxt_busy = 1'b1;
          nxt_err = 1'b0;
        end else if (nxt_set) begin
          nxt_state = DPCH_SET;
        end
      end
      DPCH_SET: begin
        if (!nxt_set) begin
          nxt_state = DPCH_IDLE;
        end else if (nxt_run) begin
          nxt_state = DPCH_BUSY;
          nxt_busy = 1'b1;
          nxt_err = 1'b0;
        end
      end
      DPCH_BUSY: begin
        if (!nxt_set) begin
          nxt_state = DPCH_IDLE;
        end else if (!nxt_run) begin
          nxt_state = DPCH_SET; // Interrupted, busy stays
        end else if (fail_s) begin
          nxt_state = DPCH_DONE;
          nxt_err = 1'b1;
          nxt_busy = 1'b0;
        end else if (done_s) begin
          nxt_state = DPCH_DONE;
          nxt_busy = 1'b0;
        end
      end
      DPCH_DONE: begin
        if (!nxt_set) begin
          nxt_state = DPCH_IDLE;
        end else if (!nxt_run) begin
          nxt_state = DPCH_SET;
        end
      end
      default: begin
        nxt_state = DPCH_IDLE;
      end
    endcase
    if (!nxt_set) begin
      nxt_busy = 1'b0;
      nxt_err = 1'b0;
    end
  end

  // Event set wins over clear; clear when idle or master changes state
  always_comb begin
    if (busy_fall || err_rise) begin
      nxt_chg = 1'b1;
    end else if (!nxt_set || ctl_change || wr_zero) begin
      nxt_chg = 1'b0;
    end else begin
      nxt_chg = chg_ff;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_ff <= DPCH_IDLE;
      set_ff <= 1'b0;
      run_ff <= 1'b0;
      busy_ff <= 1'b0;
      err_ff <= 1'b0;
      chg_ff <= 1'b0;
    end else if (clk_en) begin
      state_ff <= nxt_state;
      set_ff <= nxt_set;
      run_ff <= nxt_run;
      busy_ff <= nxt_busy;
      err_ff <= nxt_err;
      chg_ff <= nxt_chg;
    end
  end

  // Registered outputs
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      proc_status <= `DPCH_STS_RESET;
      proc_armed <= 1'b0;
      proc_run <= 1'b0;
      reply_dsw <= `DPCH_DSW_RESET;
      reply_valid <= 1'b0;
      attr_type <= 3'h0;
      attr_type_ok <= 1'b0;
      attr_fixed <= 1'b0;
      attr_len_ok <= 1'b0;
      attr_elem_bytes <= 4'h0;
    end else if (clk_en) begin
      proc_status <= {4'h0, nxt_err, nxt_busy, nxt_run,
        nxt_set};
      proc_armed <= nxt_set;
      proc_run <= nxt_run;
      reply_valid <= cycle_tick;
      if (cycle_tick) begin
        reply_dsw <= {dsw_in[15:6], chg_ff, dsw_in[4:0]};
      end
      attr_type <= attr_bus.data_type;
      attr_type_ok <= attr_bus.type_valid;
      attr_fixed <= attr_bus.fixed_len;
      attr_len_ok <= attr_bus.len_valid;
      attr_elem_bytes <= attr_bus.elem_bytes;
    end
  end

  // Assertions
  property p_busy_fall_sets_change;
    @(posedge clk) disable iff (sys_rst)
      (clk_en && busy_ff && !nxt_busy && nxt_set) |=> chg_ff;
  endproperty
  a_busy_fall_sets_change: assert property (p_busy_fall_sets_change)
    else $error("change flag not set on busy fall");

  property p_err_rise_sets_change;
    @(posedge clk) disable iff (sys_rst)
      (clk_en && !err_ff && nxt_err) |=> (chg_ff && err_ff);
  endproperty
  a_err_rise_sets_change: assert property (p_err_rise_sets_change)
    else $error("change flag not set on error rise");

  property p_zero_clears;
    @(posedge clk) disable iff (sys_rst)
      (clk_en && wr_zero) |=> (proc_status == 8'h00 && !chg_ff);
  endproperty
  a_zero_clears: assert property (p_zero_clears)
    else $error("write of zero did not clear status");

  property p_idle_no_change;
    @(posedge clk) disable iff (sys_rst)
      !set_ff |-> !chg_ff;
  endproperty
  a_idle_no_change: assert property (p_idle_no_change)
    else $error("change flag set while no procedure active");

  property p_echo;
    @(posedge clk) disable iff (sys_rst)
      (clk_en && cmd_wr) |=> (proc_status[0] == $past(cmd_wdata[0]) &&
        proc_status[1] == $past(cmd_wdata[0] && cmd_wdata[1]));
  endproperty
  a_echo: assert property (p_echo)
    else $error("control bits not mirrored");

  property p_reserved_zero;
    @(posedge clk) disable iff (sys_rst)
      proc_status[7:4] == 4'h0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved status bits not zero");

  property p_start_busy;
    @(posedge clk) disable iff (sys_rst)
      (clk_en && state_ff == DPCH_SET && nxt_set && nxt_run)
        |=> (busy_ff && proc_status[2]);
  endproperty
  a_start_busy: assert property (p_start_busy)
    else $error("busy not raised on start");

  property p_one_step_start;
    @(posedge clk) disable iff (sys_rst)
      (clk_en && state_ff == DPCH_IDLE && nxt_set && nxt_run)
        |=> (proc_status == 8'h07);
  endproperty
  a_one_step_start: assert property (p_one_step_start)
    else $error("set and start did not raise busy");

  property p_reply_carries_change;
    @(posedge clk) disable iff (sys_rst)
      (clk_en && cycle_tick) |=> (reply_valid &&
        reply_dsw[5] == $past(chg_ff));
  endproperty
  a_reply_carries_change: assert property (p_reply_carries_change)
    else $error("reply word lacks change flag");

  property p_fail_error;
    @(posedge clk) disable iff (sys_rst)
      (clk_en && state_ff == DPCH_BUSY && nxt_set && nxt_run && fail_s)
        |=> proc_status[3];
  endproperty
  a_fail_error: assert property (p_fail_error)
    else $error("error bit not set on failure");

  property p_reserved_len;
    @(posedge clk) disable iff (sys_rst)
      (attr_word[18:16] == 3'h0) |-> !attr_bus.len_valid;
  endproperty
  a_reserved_len: assert property (p_reserved_len)
    else $error("reserved length code accepted");

  c_done: cover property (@(posedge clk) disable iff (sys_rst)
    state_ff == DPCH_BUSY ##1 state_ff == DPCH_DONE && !err_ff);
  c_fail: cover property (@(posedge clk) disable iff (sys_rst)
    state_ff == DPCH_DONE && err_ff);
  c_interrupt: cover property (@(posedge clk) disable iff (sys_rst)
    state_ff == DPCH_BUSY ##1 state_ff == DPCH_SET);
  c_resume: cover property (@(posedge clk) disable iff (sys_rst)
    state_ff == DPCH_SET && busy_ff ##1 state_ff == DPCH_BUSY);
endmodule // dpch_core

//--- tb/dpch_master_model.sv
// Fieldbus master model: writes procedure commands, makes cyclic ticks
`timescale 1ns/10ps
module dpch_master_model (
  // Clock
  input wire logic clk,
  // Command write
  output logic cmd_wr,
  output logic [7:0] cmd_wdata,
  // Cyclic reply
  output logic cycle_tick,
  input wire logic [15:0] reply_dsw,
  input wire logic reply_valid
);
  logic [1:0] tick_cnt;
  initial begin
    cmd_wr = 1'b0;
    cmd_wdata = 8'h00;
    cycle_tick = 1'b0;
    tick_cnt = 2'h0;
  end
  // One reply request every fourth cycle
  always @(negedge clk) begin
    tick_cnt <= tick_cnt + 2'h1;
    cycle_tick <= (tick_cnt == 2'h3);
  end
  // Only the master sets, starts and stops; 3 sets and starts at once
  task automatic issue(input logic [7:0] v);
    @(negedge clk);
    cmd_wr = 1'b1;
    cmd_wdata = v;
    @(negedge clk);
    cmd_wr = 1'b0;
    cmd_wdata = ~v;
  endtask
  // Watch the change flag in replies instead of polling the status
  task automatic wait_flag(input logic want, output logic seen);
    seen = 1'b0;
    for (int i = 0; i < 64 && !seen; i++) begin
      @(posedge clk);
      #1;
      if (reply_valid === 1'b1 && reply_dsw[5] === want) seen = 1'b1;
    end
  endtask
endmodule // dpch_master_model

//--- tb/drive_procedure_command_handshake_tb_top.sv
// Testbench for the drive procedure command handshake block
`timescale 1ns/10ps
module drive_procedure_command_handshake_tb_top;
  import dpch_pkg::*;
  logic clk, sys_rst, clk_en, cmd_wr, proc_done, proc_fail, cycle_tick;
  logic [7:0] cmd_wdata, proc_status;
  logic [15:0] dsw_in, reply_dsw;
  logic [31:0] attr_word;
  logic proc_armed, proc_run, reply_valid, attr_type_ok;
  logic attr_fixed, attr_len_ok, seen;
  logic [2:0] attr_type;
  logic [3:0] attr_elem_bytes;
  int error_cnt = 0;
  int n_tests = 0;

  dpch_core dut_u (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .cmd_wr(cmd_wr), .cmd_wdata(cmd_wdata), .proc_done(proc_done),
    .proc_fail(proc_fail), .cycle_tick(cycle_tick), .dsw_in(dsw_in),
    .attr_word(attr_word), .proc_status(proc_status),
    .proc_armed(proc_armed), .proc_run(proc_run), .reply_dsw(reply_dsw),
    .reply_valid(reply_valid), .attr_type(attr_type),
    .attr_type_ok(attr_type_ok), .attr_fixed(attr_fixed),
    .attr_len_ok(attr_len_ok), .attr_elem_bytes(attr_elem_bytes));

  dpch_master_model master_u (.clk(clk), .cmd_wr(cmd_wr),
    .cmd_wdata(cmd_wdata), .cycle_tick(cycle_tick),
    .reply_dsw(reply_dsw), .reply_valid(reply_valid));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic chk(input string what, input logic [31:0] got,
    input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic complete_run;
    $display("Counts: %0d checks, %0d mismatches", n_tests, error_cnt);
    if (n_tests > 0 && error_cnt == 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Bounded wait for a status value, then compare it
  task automatic wait_sts(input logic [7:0] exp);
    for (int i = 0; i < 40 && proc_status !== exp; i++) @(negedge clk);
    chk("status", proc_status, exp);
    if (proc_status !== exp) complete_run();
  endtask

  // Watch replies for a flag value, then go on at a falling edge
  task automatic await_flag(input string what, input logic want);
    master_u.wait_flag(want, seen);
    @(negedge clk);
    chk(what, seen, 1'b1);
    if (!seen) complete_run();
  endtask

  task automatic t_reset;
    chk("status", proc_status, 8'h00);
    chk("armed", proc_armed, 1'b0);
    chk("dsw", reply_dsw, 16'h0000);
    chk("valid", reply_valid, 1'b0);
    $display("Test reset done");
  endtask

  task automatic t_done;
    master_u.issue(8'h03);
    chk("status", proc_status, 8'h07);
    chk("run", proc_run, 1'b1);
    chk("armed", proc_armed, 1'b1);
    proc_done = 1'b1;
    wait_sts(8'h03);
    await_flag("flag set", 1'b1);
    chk("dsw", reply_dsw, 16'ha5e3);
    master_u.issue(8'h03);
    chk("same write", proc_status, 8'h03);
    await_flag("flag kept", 1'b1);
    proc_done = 1'b0;
    master_u.issue(8'h00);
    chk("status", proc_status, 8'h00);
    await_flag("flag clear", 1'b0);
    chk("dsw", reply_dsw, 16'ha5c3);
    $display("Test done path done");
  endtask

  task automatic t_fail;
    master_u.issue(8'h03);
    chk("status", proc_status, 8'h07);
    proc_fail = 1'b1;
    dsw_in = 16'h5a3c;
    wait_sts(8'h0b);
    await_flag("flag err", 1'b1);
    chk("dsw", reply_dsw, 16'h5a3c);
    proc_fail = 1'b0;
    master_u.issue(8'h01);
    chk("interrupt err", proc_status, 8'h09);
    await_flag("flag ctl", 1'b0);
    chk("dsw", reply_dsw, 16'h5a1c);
    master_u.issue(8'h00);
    chk("status", proc_status, 8'h00);
    $display("Test fail path done");
  endtask

  task automatic t_rst_mid;
    master_u.issue(8'h03);
    chk("pre reset", proc_status, 8'h07);
    sys_rst = 1'b1;
    @(negedge clk);
    chk("status rst", proc_status, 8'h00);
    chk("run rst", proc_run, 1'b0);
    chk("dsw rst", reply_dsw, 16'h0000);
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    master_u.issue(8'h03);
    chk("restart", proc_status, 8'h07);
    master_u.issue(8'h00);
    chk("stop", proc_status, 8'h00);
    $display("Test mid reset done");
  endtask

  task automatic t_ctl;
    master_u.issue(8'h03);
    master_u.issue(8'h01);
    chk("interrupt", proc_status, 8'h05);
    master_u.issue(8'h03);
    chk("resume", proc_status, 8'h07);
    master_u.issue(8'h00);
    chk("cancel", proc_status, 8'h00);
    master_u.issue(8'hfd);
    chk("rsvd set", proc_status, 8'h01);
    chk("armed", proc_armed, 1'b1);
    master_u.issue(8'hfe);
    chk("rsvd start", proc_status, 8'h00);
    clk_en = 1'b0;
    master_u.issue(8'h03);
    chk("frozen", proc_status, 8'h00);
    clk_en = 1'b1;
    $display("Test control bits done");
  endtask

  task automatic t_attr;
    logic [5:0] c;
    logic [31:0] len_tab;
    // Element bytes per length code, one nibble per code
    len_tab = 32'h84218420;
    for (int i = 0; i < 64; i++) begin
      c = i[5:0];
      @(negedge clk);
      attr_word = {c, c[5:3], c[5:3], 1'b1, c[2:0], {2{~c}}, 4'h5};
      @(negedge clk);
      chk("type", attr_type, c[5:3]);
      chk("type ok", attr_type_ok, c[5:3] != 3'h7);
      chk("fixed", attr_fixed, !c[2]);
      chk("len ok", attr_len_ok, c[2:0] != 3'h0);
      chk("elem", attr_elem_bytes, len_tab[4*c[2:0] +: 4]);
    end
    $display("Test attribute done");
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    $display("MISMATCH run time expected end seen hang");
    complete_run();
  end

  initial begin
    sys_rst = 1'b1;
    clk_en = 1'b1;
    proc_done = 1'b0;
    proc_fail = 1'b0;
    dsw_in = 16'ha5c3;
    attr_word = 32'h00000000;
    repeat (6) @(negedge clk);
    sys_rst = 1'b0;
    t_reset();
    t_done();
    t_fail();
    t_rst_mid();
    t_ctl();
    t_attr();
    complete_run();
  end
endmodule // drive_procedure_command_handshake_tb_top
